// ==== pvic_pkg.sv ====
// constants, types and register offsets of the vectored interrupt controller
// assumes one 100 MHz clock shared by the controller and the core end
package pvic_pkg;

	localparam int NUM_SRC     = 46;
	localparam int NUM_FIXED   = 6;
	localparam int PRIO_WORDS  = 5;
	localparam int PRIO_BITS   = 80;
	localparam int EN_WORDS    = 3;
	localparam int DATA_W      = 16;
	localparam int ADDR_W      = 5;
	localparam int VEC_W       = 6;
	localparam int VBASE_W     = 14;
	localparam int FVH_W       = 5;
	localparam int VADDR_W     = 21;
	localparam int STACK_DEPTH = 4;

	typedef logic [1:0]         level_t;
	typedef logic [VEC_W-1:0]   vec_t;
	typedef logic [VADDR_W-1:0] vaddr_t;
	typedef logic [DATA_W-1:0]  word_t;
	typedef logic [ADDR_W-1:0]  addr_t;

	localparam level_t FIXED_LEVEL = 2'h3;
	localparam level_t FAST_LEVEL  = 2'h2;
	localparam level_t TOP_LEVEL   = 2'h3;

	// register word offsets
	localparam addr_t OFF_PRIO0 = 5'h00;
	localparam addr_t OFF_VBASE = 5'h05;
	localparam addr_t OFF_FM0   = 5'h06;
	localparam addr_t OFF_FVL0  = 5'h07;
	localparam addr_t OFF_FVH0  = 5'h08;
	localparam addr_t OFF_FM1   = 5'h09;
	localparam addr_t OFF_FVL1  = 5'h0a;
	localparam addr_t OFF_FVH1  = 5'h0b;
	localparam addr_t OFF_PEND0 = 5'h0c;
	localparam addr_t OFF_CTRL  = 5'h12;
	localparam addr_t OFF_EN0   = 5'h13;
	localparam addr_t OFF_STAT  = 5'h16;
	localparam addr_t OFF_IMASK = 5'h17;

	// event status bits
	localparam int ST_TAKEN = 0;
	localparam int ST_FAST  = 1;
	localparam int ST_WAKE  = 2;
	localparam int ST_W     = 3;

	// first fetch address after reset
	localparam vaddr_t BOOT_ADDR = 21'h000000;
	// subroutine_jump_opcode value, arbitrary plain default
	localparam word_t SUBR_JUMP_OPCODE = 16'he200;

	typedef enum logic [0:0] {
		ST_IDLE  = 1'b0,
		ST_FETCH = 1'b1
	} core_state_e;

endpackage : pvic_pkg

// ==== pvic_link_if.sv ====
// link between the interrupt controller and the processor core end
// assumes both ends run on the same clock; no clocking block
`timescale 1ns/100ps
interface pvic_link_if;
	import pvic_pkg::*;

	logic   pending;     // permitted request waiting
	vec_t   vector;      // selected vector number
	level_t level;       // level of the selected request
	logic   fast;        // selected request is a fast interrupt
	vaddr_t vaddr;       // jump address, or boot address while boot
	logic   boot;        // boot address valid
	logic   boot_take;   // core takes the boot address
	logic   take;        // core takes the pending request
	level_t status_mask; // core status mask bits
	logic   low_power;   // core in wait or stop
	logic   clk_restart; // ask the clock unit to restart clocks

	modport ctrl (
		output pending, vector, level, fast, vaddr, boot, clk_restart,
		input  boot_take, take, status_mask, low_power
	);
	modport core (
		input  pending, vector, level, fast, vaddr, boot, clk_restart,
		output boot_take, take, status_mask, low_power
	);

endinterface : pvic_link_if

// ==== interrupt_arbiter.sv ====
// interrupt arbiter: priorities, vector address, fast channels and wake-up
// assumes request lines and the register port are on clk_i
`timescale 1ns/100ps
module interrupt_arbiter
	import pvic_pkg::*;
(
	input  wire logic            clk_i,
	input  wire logic            reset_i,
	input  wire logic [NUM_SRC-1:0] irq_src_i,
	input  wire addr_t           addr_i,
	input  wire word_t           wdata_i,
	input  wire logic            wr_i,
	input  wire logic            rd_i,
	output word_t                rdata_o,
	output logic                 irq_o,
	pvic_link_if.ctrl            link
);

	typedef struct packed {
		logic [PRIO_BITS-1:0] prio;
		logic [VBASE_W-1:0]   vbase;
		vec_t                 fm0;
		vec_t                 fm1;
		word_t                fvl0;
		word_t                fvl1;
		logic [FVH_W-1:0]     fvh0;
		logic [FVH_W-1:0]     fvh1;
		logic [NUM_SRC-1:0]   enable;
		logic [NUM_SRC-1:0]   wake_en;
		logic                 lp_d;
		logic [ST_W-1:0]      status;
		logic [ST_W-1:0]      imask;
		logic                 irq;
		word_t                rdata;
		logic                 pending;
		vec_t                 vector;
		level_t               level;
		logic                 fast;
		vaddr_t               vaddr;
		logic                 boot;
		logic                 clk_restart;
	} arb_s;

	arb_s s;
	arb_s next_s;

	// level of a source: fixed ones ignore the priority fields
	function automatic level_t level_of(
		input logic [PRIO_BITS-1:0] p,
		input int                   src
	);
		level_t l;
		l = FIXED_LEVEL;
		if (src >= NUM_FIXED) begin
			l = p[2*(src-NUM_FIXED) +: 2];
		end
		return l;
	endfunction : level_of

	// sixteen-bit slice of a wide vector, for register reads
	function automatic word_t slice_of(
		input logic [3*DATA_W-1:0] v,
		input int                  w
	);
		return v[DATA_W*w +: DATA_W];
	endfunction : slice_of

	logic [NUM_SRC-1:0]  active;
	logic [3*DATA_W-1:0] active_w;
	logic [3*DATA_W-1:0] enable_w;
	logic                found;
	level_t              best_level;
	vec_t                best_vec;
	level_t              lvl;
	logic                hit0;
	logic                hit1;
	logic [ST_W-1:0]     events;
	logic                woke;
	logic                next_restart;
	int                  word;

	assign active   = irq_src_i & s.enable;
	assign active_w = {2'h0, active};
	assign enable_w = {2'h0, s.enable};

	// priority encode: highest permitted level, then lowest number
	always_comb begin
		found      = 1'b0;
		best_level = 2'h0;
		best_vec   = 6'h00;
		lvl        = 2'h0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			lvl = level_of(s.prio, i);
			if (active[i] && lvl >= link.status_mask) begin
				if (!found || lvl >= best_level) begin
					found      = 1'b1;
					best_level = lvl;
					best_vec   = vec_t'(i);
				end
			end
		end
	end

	// fast match on both channels, channel 0 wins a double match
	assign hit0 = found && best_vec == s.fm0 && best_level == FAST_LEVEL;
	assign hit1 = found && best_vec == s.fm1 && best_level == FAST_LEVEL;

	// clock restart for the next cycle, kept out of next_s so that the
	// status logic never reads a field of the struct that it feeds
	assign next_restart = link.low_power &&
		|(irq_src_i & (s.lp_d ? s.wake_en : s.enable));

	// events that set sticky status bits
	assign woke = !s.clk_restart && next_restart;
	always_comb begin
		events           = '0;
		events[ST_TAKEN] = link.take && s.pending;
		events[ST_FAST]  = link.take && s.pending && s.fast;
		events[ST_WAKE]  = woke;
	end

	// next state: registers, selection, wake and boot
	always_comb begin
		next_s = s;
		word   = 0;

		// register writes
		if (wr_i) begin
			if (addr_i < OFF_VBASE) begin
				word = int'(addr_i - OFF_PRIO0);
				next_s.prio[DATA_W*word +: DATA_W] = wdata_i;
			end else if (addr_i >= OFF_EN0 && addr_i < OFF_STAT) begin
				word = int'(addr_i - OFF_EN0);
				if (word == EN_WORDS - 1) begin
					next_s.enable[NUM_SRC-1:2*DATA_W] =
						wdata_i[NUM_SRC-2*DATA_W-1:0];
				end else begin
					next_s.enable[DATA_W*word +: DATA_W] = wdata_i;
				end
			end
			case (addr_i)
				OFF_VBASE: next_s.vbase = wdata_i[VBASE_W-1:0];
				OFF_FM0:   next_s.fm0   = wdata_i[VEC_W-1:0];
				OFF_FVL0:  next_s.fvl0  = wdata_i;
				OFF_FVH0:  next_s.fvh0  = wdata_i[FVH_W-1:0];
				OFF_FM1:   next_s.fm1   = wdata_i[VEC_W-1:0];
				OFF_FVL1:  next_s.fvl1  = wdata_i;
				OFF_FVH1:  next_s.fvh1  = wdata_i[FVH_W-1:0];
				OFF_IMASK: next_s.imask = wdata_i[ST_W-1:0];
				default:   next_s.vbase = s.vbase;
			endcase
		end

		// sticky status: a new event wins over a write-one clear
		next_s.status = s.status & ~((wr_i && addr_i == OFF_STAT) ?
			wdata_i[ST_W-1:0] : 3'h0);
		next_s.status = next_s.status | events;
		next_s.irq    = |(next_s.status & next_s.imask);

		// register reads, data one cycle after the strobe
		next_s.rdata = 16'h0000;
		if (rd_i) begin
			if (addr_i < OFF_VBASE) begin
				word = int'(addr_i - OFF_PRIO0);
				next_s.rdata = s.prio[DATA_W*word +: DATA_W];
			end else if (addr_i >= OFF_PEND0 && addr_i < OFF_PEND0 + 5'h03) begin
				next_s.rdata = slice_of(active_w, int'(addr_i - OFF_PEND0));
			end else if (addr_i >= OFF_EN0 && addr_i < OFF_STAT) begin
				next_s.rdata = slice_of(enable_w, int'(addr_i - OFF_EN0));
			end
			case (addr_i)
				OFF_VBASE: next_s.rdata = {2'h0, s.vbase};
				OFF_FM0:   next_s.rdata = {10'h000, s.fm0};
				OFF_FVL0:  next_s.rdata = s.fvl0;
				OFF_FVH0:  next_s.rdata = {11'h000, s.fvh0};
				OFF_FM1:   next_s.rdata = {10'h000, s.fm1};
				OFF_FVL1:  next_s.rdata = s.fvl1;
				OFF_FVH1:  next_s.rdata = {11'h000, s.fvh1};
				OFF_CTRL:  next_s.rdata = {5'h00, s.boot, s.pending,
					s.fast, s.level, s.vector};
				OFF_STAT:  next_s.rdata = {13'h0000, s.status};
				OFF_IMASK: next_s.rdata = {13'h0000, s.imask};
				default:   next_s.rdata = next_s.rdata;
			endcase
		end

		// selection shown to the core ahead of its take
		next_s.pending = found;
		next_s.vector  = best_vec;
		next_s.level   = best_level;
		next_s.fast    = hit0 || hit1;
		if (hit0) begin
			next_s.vaddr = {s.fvh0, s.fvl0};
		end else if (hit1) begin
			next_s.vaddr = {s.fvh1, s.fvl1};
		end else begin
			next_s.vaddr = {1'b0, s.vbase, best_vec};
		end
		if (s.boot) begin
			next_s.vaddr = BOOT_ADDR;
		end
		if (link.boot_take) begin
			next_s.boot = 1'b0;
		end

		// wake sources frozen when the core enters wait or stop
		next_s.lp_d = link.low_power;
		if (link.low_power && !s.lp_d) begin
			next_s.wake_en = s.enable;
		end
		next_s.clk_restart = next_restart;
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s       <= '0;
			s.boot  <= 1'b1;
			s.vaddr <= BOOT_ADDR;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from the state
	assign rdata_o          = s.rdata;
	assign irq_o            = s.irq;
	assign link.pending     = s.pending;
	assign link.vector      = s.vector;
	assign link.level       = s.level;
	assign link.fast        = s.fast;
	assign link.vaddr       = s.vaddr;
	assign link.boot        = s.boot;
	assign link.clk_restart = s.clk_restart;

endmodule : interrupt_arbiter

// ==== core_end.sv ====
// processor core end of the interrupt link: take, fetch, nest, sleep
// assumes the instruction memory answers fetch requests on clk_i
`timescale 1ns/100ps
module core_end
	import pvic_pkg::*;
(
	input  wire logic   clk_i,
	input  wire logic   reset_i,
	input  wire logic   enter_lp_i,
	input  wire logic   rti_i,
	input  wire word_t  instr_i,
	input  wire logic   instr_valid_i,
	output logic        fetch_req_o,
	output vaddr_t      fetch_addr_o,
	output logic        fast_mode_o,
	output level_t      status_mask_o,
	output logic        low_power_o,
	pvic_link_if.core   link
);

	typedef struct packed {
		core_state_e                  state;
		vaddr_t                       addr;
		logic                         fast;
		logic                         fast_mode;
		level_t                       mask;
		logic [STACK_DEPTH-1:0][1:0]  stack;
		logic [2:0]                   sp;
		logic                         lp;
	} core_s;

	core_s s;
	core_s next_s;

	logic take;
	logic boot_take;

	// take requests only while awake and idle; boot address first
	assign boot_take = s.state == ST_IDLE && link.boot;
	assign take      = s.state == ST_IDLE && !link.boot && link.pending
		&& !s.lp;

	// next state
	always_comb begin
		next_s = s;
		unique case (s.state)
			ST_IDLE: begin
				if (boot_take) begin
					next_s.addr  = link.vaddr;
					next_s.fast  = 1'b0;
					next_s.state = ST_FETCH;
				end else if (take) begin
					next_s.addr  = link.vaddr;
					next_s.fast  = link.fast;
					next_s.state = ST_FETCH;
					// raise mask one above the taken level (level 3 keeps mask 3), save the old one while the stack has room
					next_s.mask  = (link.level == TOP_LEVEL) ? TOP_LEVEL :
						level_t'(link.level + 2'h1);
					if (s.sp < 3'(STACK_DEPTH)) begin
						next_s.stack[s.sp[1:0]] = s.mask;
						next_s.sp = s.sp + 3'h1;
					end
				end
			end
			ST_FETCH: begin
				if (instr_valid_i) begin
					next_s.fast_mode = s.fast &&
						instr_i != SUBR_JUMP_OPCODE;
					next_s.state     = ST_IDLE;
				end
			end
		endcase

		// return from exception restores the saved mask
		if (rti_i && s.state == ST_IDLE && s.sp != 3'h0) begin
			next_s.sp        = s.sp - 3'h1;
			next_s.mask      = s.stack[2'(s.sp - 3'h1)];
			next_s.fast_mode = 1'b0;
		end

		// sleep until the controller asks for the clocks back
		next_s.lp = (s.lp || enter_lp_i) && !link.clk_restart;
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// link and user outputs
	assign link.take        = take;
	assign link.boot_take   = boot_take;
	assign link.status_mask = s.mask;
	assign link.low_power   = s.lp;
	assign fetch_req_o      = s.state == ST_FETCH;
	assign fetch_addr_o     = s.addr;
	assign fast_mode_o      = s.fast_mode;
	assign status_mask_o    = s.mask;
	assign low_power_o      = s.lp;

endmodule : core_end

// ==== pvic_props.sv ====
// assertions on the link between interrupt arbiter and core end
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
module pvic_props
	import pvic_pkg::*;
(
	input wire logic   clk_i,
	input wire logic   reset_i,
	input wire logic   pending,
	input wire vec_t   vector,
	input wire level_t level,
	input wire logic   fast,
	input wire vaddr_t vaddr,
	input wire logic   boot,
	input wire logic   boot_take,
	input wire logic   take,
	input wire level_t status_mask,
	input wire logic   low_power,
	input wire logic   clk_restart
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	// selection, masking and address forming
	AST_VEC_RANGE: assert property (pending |-> vector <= 6'd45)
		else $error("vector above last source");
	AST_MASK_GATE: assert property (
		pending |-> level >= $past(status_mask))
		else $error("masked level shown as pending");
	AST_FAST_LEVEL: assert property (fast |-> level == FAST_LEVEL)
		else $error("fast flag on a level other than two");
	AST_NORMAL_ADDR: assert property (
		pending && !fast && !boot |-> vaddr[5:0] == vector && !vaddr[20])
		else $error("normal address does not end in vector");
	AST_BOOT_ADDR: assert property (boot |-> vaddr == BOOT_ADDR)
		else $error("boot address not driven");
	AST_BOOT_DONE: assert property (
		boot_take && !reset_i |=> !boot)
		else $error("boot flag stays after boot take");

	// taking and nesting
	AST_TAKE_OK: assert property (
		take |-> pending && !boot && !low_power)
		else $error("take without permitted request");
	AST_NEST_MASK: assert property (take |=> status_mask ==
		($past(level) == 2'h3 ? 2'h3 : $past(level) + 2'h1))
		else $error("mask not raised above taken level");

	// wake from low power
	AST_WAKE_LP: assert property (clk_restart |-> $past(low_power))
		else $error("clock restart outside low power");
	AST_WAKE_EXIT: assert property (clk_restart |=> !low_power)
		else $error("core stays asleep after restart");
endmodule : pvic_props

// ==== priority_vectored_interrupt_ctrl_bench.sv ====
// testbench: arbiter and core end joined by the link interface
// assumes the package, interface and both design modules compile first
`timescale 1ns/100ps
module priority_vectored_interrupt_ctrl_bench;
	import pvic_pkg::*;
	logic               clk_i;
	logic               reset_i;
	logic               wr_i;
	logic               rd_i;
	logic               iv;
	logic               irq_o;
	logic               fr;
	logic               fm;
	logic               lpo;
	logic [1:0]         pul;
	logic [NUM_SRC-1:0] src;
	addr_t              addr;
	word_t              wdata;
	word_t              rdata;
	word_t              instr;
	vaddr_t             faddr;
	level_t             smask;
	int                 err_total = 0;
	int                 checked = 0;

	pvic_link_if link ();
	interrupt_arbiter i_interrupt_arbiter (.clk_i(clk_i),
		.reset_i(reset_i), .irq_src_i(src), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
		.irq_o(irq_o), .link(link));
	core_end i_core_end (.clk_i(clk_i), .reset_i(reset_i),
		.enter_lp_i(pul[0]), .rti_i(pul[1]), .instr_i(instr),
		.instr_valid_i(iv), .fetch_req_o(fr), .fetch_addr_o(faddr),
		.fast_mode_o(fm), .status_mask_o(smask), .low_power_o(lpo),
		.link(link));
	pvic_props i_pvic_props (.clk_i(clk_i), .reset_i(reset_i),
		.pending(link.pending), .vector(link.vector),
		.level(link.level), .fast(link.fast), .vaddr(link.vaddr),
		.boot(link.boot), .boot_take(link.boot_take),
		.take(link.take), .status_mask(link.status_mask),
		.low_power(link.low_power), .clk_restart(link.clk_restart));

	// verdict and end of run
	task automatic end_sim;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim

	// compare and count
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %0t saw %h expected %h", $time, s, e);
		end
	endtask : chk

	// wait n edges, then let their updates land
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : cyc

	// register port write and read
	task automatic wr(input addr_t a, input word_t d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input addr_t a, input word_t e);
		@(posedge clk_i);
		addr <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk(rdata, e);
	endtask : rd

	// request lines, core pulses, instruction delivery
	task automatic srq(input int n, input logic v);
		@(posedge clk_i);
		src[n] <= v;
	endtask : srq
	task automatic pls(input logic [1:0] m);
		@(posedge clk_i);
		pul <= m;
		@(posedge clk_i);
		pul <= 2'b00;
	endtask : pls
	task automatic fin(input word_t v);
		@(posedge clk_i);
		instr <= v;
		iv <= 1'b1;
		@(posedge clk_i);
		iv <= 1'b0;
	endtask : fin

	// core stays in its boot fetch while arbitration is probed
	task automatic t_boot;
		cyc(3);
		chk(fr, 1'b1);
		chk(faddr, BOOT_ADDR);
		chk(link.boot, 1'b0);
	endtask : t_boot

	task automatic t_prio;
		wr(OFF_VBASE, 16'h0abc);
		wr(OFF_EN0, 16'h02c1);
		wr(OFF_PRIO0, 16'h0089);
		srq(9, 1'b1);
		srq(7, 1'b1);
		cyc(3);
		chk(link.vector, 6'd7);
		chk(link.vaddr, {1'b0, 14'h0abc, 6'd7});
		srq(6, 1'b1);
		srq(0, 1'b1);
		cyc(3);
		chk(link.level, 2'h3);
		chk(link.vector, 6'd0);
		rd(OFF_CTRL, 16'h02c0);
		rd(5'h1f, 16'h0000);
		srq(0, 1'b0);
	endtask : t_prio

	task automatic t_fast;
		wr(OFF_FM1, 16'h0009);
		wr(OFF_FVL1, 16'h1234);
		wr(OFF_FVH1, 16'h0015);
		srq(7, 1'b0);
		srq(6, 1'b0);
		cyc(3);
		chk(link.fast, 1'b1);
		chk(link.vaddr, 21'h151234);
		wr(OFF_FM0, 16'h0009);
		wr(OFF_FVL0, 16'h4321);
		cyc(2);
		chk(link.vaddr, 21'h004321);
		wr(OFF_PRIO0, 16'h0049);
		cyc(2);
		chk(link.vector, 6'd9);
		chk(link.fast, 1'b0);
		wr(OFF_PRIO0, 16'h0089);
	endtask : t_fast

	// take, nest, preempt by fixed level, then unwind
	task automatic t_nest;
		srq(6, 1'b1);
		fin(16'h0000);
		cyc(3);
		chk(faddr, 21'h004321);
		chk(smask, 2'h3);
		// fast vector holding a subroutine jump: no fast handling
		fin(SUBR_JUMP_OPCODE);
		cyc(2);
		chk(fm, 1'b0);
		chk(link.pending, 1'b0);
		srq(0, 1'b1);
		cyc(4);
		chk(faddr, {1'b0, 14'h0abc, 6'h00});
		// drop the fixed request before the core idles, or it retakes it
		srq(0, 1'b0);
		fin(16'h0000);
		pls(2'b10);
		cyc(2);
		chk(smask, 2'h3);
		// unwinding to mask 0 lets the level-2 fast request in again
		pls(2'b10);
		cyc(4);
		chk(faddr, 21'h004321);
		srq(9, 1'b0);
		srq(6, 1'b0);
		fin(16'h0000);
		cyc(2);
		chk(fm, 1'b1);
		pls(2'b10);
		cyc(2);
		chk(smask, 2'h0);
	endtask : t_nest

	// sticky status, mask and level interrupt
	task automatic t_irq;
		rd(OFF_STAT, 16'h0003);
		chk(irq_o, 1'b0);
		wr(OFF_IMASK, 16'h0001);
		cyc(2);
		chk(irq_o, 1'b1);
		wr(OFF_STAT, 16'h0007);
		cyc(2);
		chk(irq_o, 1'b0);
		rd(OFF_STAT, 16'h0000);
	endtask : t_irq

	// only sources enabled before sleep may wake the core
	task automatic t_wake;
		wr(OFF_EN0, 16'h0040);
		pls(2'b01);
		cyc(3);
		// source 7 is enabled only after sleep, so it must not wake
		wr(OFF_EN0, 16'h00c0);
		srq(7, 1'b1);
		cyc(4);
		chk(link.clk_restart, 1'b0);
		chk(lpo, 1'b1);
		srq(6, 1'b1);
		cyc(1);
		chk(link.clk_restart, 1'b1);
		cyc(1);
		chk(lpo, 1'b0);
		cyc(4);
		rd(OFF_STAT, 16'h0005);
	endtask : t_wake

	// clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// reset, then the scenarios in order
	initial begin
		reset_i = 1'b1;
		src = '0;
		addr = '0;
		wdata = '0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		pul = 2'b00;
		instr = '0;
		iv = 1'b0;
		repeat (6) @(posedge clk_i);
		reset_i <= 1'b0;
		t_boot();
		t_prio();
		t_fast();
		t_nest();
		t_irq();
		t_wake();
		end_sim();
	end

	// watchdog against a hang
	initial begin
		#50000;
		err_total++;
		end_sim();
	end
endmodule : priority_vectored_interrupt_ctrl_bench
